// file: rtl/eprom_prog_pkg.sv
// shared constants for the eprom read and programming controller
package eprom_prog_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int CLK_HZ = 50_000_000;
    localparam int PRIME_US = 1000;
    localparam int PRIME_CYC = (CLK_HZ / 1_000_000) * PRIME_US;
    localparam int SETUP_US = 2;
    localparam int SETUP_CYC = (CLK_HZ / 1_000_000) * SETUP_US;
    localparam int ACCESS_NS = 450;
    localparam int ACCESS_CYC =
        (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int MAX_PRIME = 25;
    localparam int FINAL_MULT = 3;
    localparam int CNT_W = 24;
    localparam int TRY_W = 5;
    localparam logic [ADDR_W-1:0] ID_PIN_MASK = 14'h0200;
    localparam logic [ADDR_W-1:0] ID_MFG_ADDR = 14'h0000;
    localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 14'h0001;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_IDENT = 2'h2;
endpackage

// file: rtl/tick_timer.sv
// loadable down counter giving a one-cycle done pulse
`timescale 1ns/10ps
module tick_timer #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic done_o,
    output logic busy_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
        logic done;
    } tim_t;
    tim_t s_q, s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load_i)
        begin
            s_d.cnt = count_i;
            s_d.busy = 1'b1;
        end
        else if (s_q.busy)
        begin
            if (s_q.cnt <= W'(1))
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign done_o = s_q.done;
    assign busy_o = s_q.busy;
endmodule

// file: rtl/eprom_prog_ctrl.sv
// host-side controller driving an eprom's pins for read, id and programming
`timescale 1ns/10ps
module eprom_prog_ctrl
#(
    parameter int PRIME_CYCLES = eprom_prog_pkg::PRIME_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [1:0] op_i,
    input wire logic [eprom_prog_pkg::ADDR_W-1:0] addr_i,
    input wire logic [eprom_prog_pkg::DATA_W-1:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic fail_o,
    output logic parity_err_o,
    output logic [eprom_prog_pkg::DATA_W-1:0] rdata_o,
    output logic [eprom_prog_pkg::ADDR_W-1:0] addr_bus_o,
    input wire logic [eprom_prog_pkg::DATA_W-1:0] byte_pins_i,
    output logic [eprom_prog_pkg::DATA_W-1:0] byte_pins_o,
    output logic byte_pins_oe_o,
    output logic chip_sel_n_o,
    output logic out_gate_n_o,
    output logic burn_strobe_n_o,
    output logic vpp_raise_o,
    output logic id_high_volt_o
);
    import eprom_prog_pkg::*;

    typedef enum logic [3:0] {
        IDLE, SETUP, PULSE, HOLD, VSETUP, VREAD, FINAL, RDSETUP, RDSAMP,
        FINISH
    } st_t;

    typedef struct packed {
        st_t st;
        logic [1:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [TRY_W-1:0] tries;
        logic final_done;
        logic busy;
        logic done;
        logic fail;
        logic perr;
        logic [ADDR_W-1:0] abus;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic cs_n;
        logic og_n;
        logic pg_n;
        logic vpp;
        logic idv;
    } ctl_t;

    ctl_t s_q, s_d;
    logic tload;
    logic [CNT_W-1:0] tcount;
    logic tdone;

    tick_timer #(.W(CNT_W)) u_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .load_i(tload),
        .count_i(tcount),
        .done_o(tdone),
        .busy_o()
    );

    always_comb
    begin
        s_d = s_q;
        tload = 1'b0;
        tcount = '0;
        s_d.done = 1'b0;
        case (s_q.st)
            IDLE:
            begin
                // deselected standby with pins released
                s_d.cs_n = 1'b1;
                s_d.og_n = 1'b1;
                s_d.pg_n = 1'b1;
                s_d.doe = 1'b0;
                s_d.vpp = 1'b0;
                s_d.idv = 1'b0;
                s_d.busy = 1'b0;
                if (start_i)
                begin
                    s_d.op = op_i;
                    s_d.wdata = wdata_i;
                    s_d.tries = '0;
                    s_d.final_done = 1'b0;
                    s_d.fail = 1'b0;
                    s_d.perr = 1'b0;
                    s_d.busy = 1'b1;
                    s_d.cs_n = 1'b0;
                    tload = 1'b1;
                    tcount = CNT_W'(SETUP_CYC);
                    if (op_i == OP_IDENT)
                    begin
                        // other lines low, low bit picks byte
                        s_d.addr = addr_i[0] ? ID_DEV_ADDR : ID_MFG_ADDR;
                        s_d.abus = s_d.addr | ID_PIN_MASK;
                        s_d.idv = 1'b1;
                        s_d.st = RDSETUP;
                    end
                    else if (op_i == OP_PROG)
                    begin
                        s_d.addr = addr_i;
                        s_d.abus = addr_i;
                        s_d.dout = wdata_i;
                        s_d.doe = 1'b1;
                        s_d.vpp = 1'b1;
                        s_d.st = SETUP;
                    end
                    else
                    begin
                        s_d.addr = addr_i;
                        s_d.abus = addr_i;
                        s_d.st = RDSETUP;
                    end
                end
            end
            SETUP:
            begin
                if (tdone)
                begin
                    s_d.pg_n = 1'b0;
                    s_d.tries = s_q.tries + TRY_W'(1);
                    tload = 1'b1;
                    tcount = CNT_W'(PRIME_CYCLES);
                    s_d.st = PULSE;
                end
            end
            PULSE:
            begin
                if (tdone)
                begin
                    s_d.pg_n = 1'b1;
                    tload = 1'b1;
                    tcount = CNT_W'(SETUP_CYC);
                    s_d.st = HOLD;
                end
            end
            HOLD:
            begin
                if (tdone)
                begin
                    s_d.doe = 1'b0;
                    if (s_q.final_done)
                    begin
                        s_d.vpp = 1'b0;
                        s_d.st = RDSETUP;
                        tcount = CNT_W'(SETUP_CYC);
                    end
                    else
                    begin
                        s_d.og_n = 1'b0;
                        s_d.st = VSETUP;
                        tcount = CNT_W'(ACCESS_CYC);
                    end
                    tload = 1'b1;
                end
            end
            VSETUP:
            begin
                if (tdone)
                begin
                    s_d.st = VREAD;
                end
            end
            VREAD:
            begin
                s_d.og_n = 1'b1;
                s_d.rdata = byte_pins_i;
                if (byte_pins_i == s_q.wdata)
                begin
                    s_d.final_done = 1'b1;
                    s_d.st = FINAL;
                    tload = 1'b1;
                    tcount = CNT_W'(SETUP_CYC);
                    s_d.dout = s_q.wdata;
                    s_d.doe = 1'b1;
                end
                else if (s_q.tries >= TRY_W'(MAX_PRIME))
                begin
                    s_d.fail = 1'b1;
                    s_d.st = FINISH;
                end
                else
                begin
                    s_d.dout = s_q.wdata;
                    s_d.doe = 1'b1;
                    tload = 1'b1;
                    tcount = CNT_W'(SETUP_CYC);
                    s_d.st = SETUP;
                end
            end
            FINAL:
            begin
                if (tdone)
                begin
                    s_d.pg_n = 1'b0;
                    tload = 1'b1;
                    tcount = CNT_W'(PRIME_CYCLES * FINAL_MULT
                        * int'(s_q.tries));
                    s_d.st = PULSE;
                end
            end
            RDSETUP:
            begin
                s_d.og_n = 1'b0;
                if (tdone)
                begin
                    tload = 1'b1;
                    tcount = CNT_W'(ACCESS_CYC);
                    s_d.st = RDSAMP;
                end
            end
            RDSAMP:
            begin
                if (tdone)
                begin
                    s_d.rdata = byte_pins_i;
                    if (s_q.op == OP_IDENT)
                    begin
                        s_d.perr = ~(^byte_pins_i);
                    end
                    else if (s_q.op == OP_PROG && byte_pins_i != s_q.wdata)
                    begin
                        s_d.fail = 1'b1;
                    end
                    s_d.og_n = 1'b1;
                    s_d.st = FINISH;
                end
            end
            FINISH:
            begin
                s_d.cs_n = 1'b1;
                s_d.idv = 1'b0;
                s_d.vpp = 1'b0;
                s_d.doe = 1'b0;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st = IDLE;
            end
            default:
            begin
                s_d.st = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
            s_q.st <= IDLE;
            s_q.cs_n <= 1'b1;
            s_q.og_n <= 1'b1;
            s_q.pg_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign busy_o = s_q.busy;
    assign done_o = s_q.done;
    assign fail_o = s_q.fail;
    assign parity_err_o = s_q.perr;
    assign rdata_o = s_q.rdata;
    assign addr_bus_o = s_q.abus;
    assign byte_pins_o = s_q.dout;
    assign byte_pins_oe_o = s_q.doe;
    assign chip_sel_n_o = s_q.cs_n;
    assign out_gate_n_o = s_q.og_n;
    assign burn_strobe_n_o = s_q.pg_n;
    assign vpp_raise_o = s_q.vpp;
    assign id_high_volt_o = s_q.idv;

    AST_NO_CONTENTION: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.doe |-> s_q.og_n)
        else $error("data driven while output gate low");
    AST_STROBE_NEEDS_VPP: assert property (@(posedge clk_i)
        disable iff (!nrst_i)
        !s_q.pg_n |-> (s_q.vpp && !s_q.cs_n && s_q.og_n && s_q.doe))
        else $error("strobe low without program conditions");
    AST_TRY_LIMIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.tries <= TRY_W'(MAX_PRIME))
        else $error("too many prime pulses");
    AST_FAIL_AT_MAX: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (s_q.st == VREAD && byte_pins_i != s_q.wdata
         && s_q.tries == TRY_W'(MAX_PRIME)) |=> s_q.fail)
        else $error("failure not flagged");
    AST_VERIFY_GATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.st == VREAD |-> (!s_q.og_n && s_q.pg_n && !s_q.doe))
        else $error("verify without gate low");
    AST_READBACK_NORMAL: assert property (@(posedge clk_i)
        disable iff (!nrst_i)
        s_q.st == RDSAMP && s_q.op == OP_PROG |-> !s_q.vpp)
        else $error("read back with supply raised");
    AST_STANDBY_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.done |-> (s_q.cs_n && !s_q.busy && !s_q.vpp && !s_q.idv))
        else $error("not standby after done");
    AST_ID_ADDR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.idv |-> (s_q.abus & ~(ID_PIN_MASK | ID_DEV_ADDR)) == '0)
        else $error("id mode with other address lines high");

    // strobe release keeps data driven through the hold time
    sequence s_pulse_end;
        s_q.st == PULSE && tdone;
    endsequence
    sequence s_strobe_up;
        s_q.st == HOLD && s_q.pg_n && s_q.doe;
    endsequence
    AST_PULSE_RELEASE: assert property (@(posedge clk_i)
        disable iff (!nrst_i)
        s_pulse_end |=> s_strobe_up)
        else $error("strobe not released with data held");

    // every prime pulse is followed by a verify read
    sequence s_prime_hold_end;
        s_q.st == HOLD && tdone && !s_q.final_done;
    endsequence
    sequence s_verify_open;
        s_q.st == VSETUP && !s_q.og_n && !s_q.doe && s_q.pg_n;
    endsequence
    AST_VERIFY_EACH: assert property (@(posedge clk_i)
        disable iff (!nrst_i)
        s_prime_hold_end |=> s_verify_open)
        else $error("prime pulse not followed by verify");
endmodule

// file: tb/eprom_model.sv
// behavioural 16K x 8 eprom seen from the controller pins
`timescale 1ns/10ps
module eprom_model #(
    parameter logic [6:0] MFG = 7'h2C, // arbitrary value
    parameter logic [6:0] DEV = 7'h51 // arbitrary value
) (
    input wire logic clk_i,
    input wire logic [13:0] addr_i,
    input wire logic [7:0] host_i,
    input wire logic host_oe_i,
    input wire logic cs_n_i,
    input wire logic og_n_i,
    input wire logic pgm_n_i,
    input wire logic vpp_i,
    input wire logic idh_i,
    output logic [7:0] bus_o
);
    logic [7:0] mem [0:16383];
    logic [7:0] last = 8'h00;
    logic [7:0] q;
    logic [6:0] code;
    logic q_oe;
    logic pgm_q = 1'b1;
    logic bad_par = 1'b0;
    int need = 1;
    int hits = 0;
    int len = 0;
    int viol = 0;
    int lens[$];
    initial
    begin
        foreach (mem[i])
            mem[i] = 8'hFF;
    end
    assign code = addr_i[0] ? DEV : MFG;
    assign q = idh_i ? {~^code ^ bad_par, code} : mem[addr_i];
    assign q_oe = !cs_n_i && !og_n_i && (pgm_n_i || idh_i);
    // released lines show the inverse of the last value
    assign bus_o = q_oe ? q : (host_oe_i ? host_i : ~last);
    always @(posedge clk_i)
    begin
        pgm_q <= pgm_n_i;
        if (q_oe)
            last <= q;
        if (q_oe && host_oe_i)
            viol++;
        if (idh_i && !cs_n_i && (addr_i & 14'h3DFE) != 14'h0000)
            viol++;
        if (!cs_n_i && og_n_i && vpp_i && !pgm_n_i)
        begin
            len++;
            if (!host_oe_i || !$stable(host_i) || !$stable(addr_i))
                viol++;
        end
        if (pgm_n_i && !pgm_q && len > 0)
        begin
            lens.push_back(len);
            hits++;
            // bits stick only after enough pulses, and only to zero
            if (hits >= need)
                mem[addr_i] <= mem[addr_i] & host_i;
            len = 0;
        end
    end
endmodule

// file: tb/eprom_prog_ctrl_tb_top.sv
// self-checking bench for the eprom programming controller
`timescale 1ns/10ps
`define CHK(n, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("BAD %s exp %h got %h", n, e, g); \
        end \
    end
module eprom_prog_ctrl_tb_top;
    import eprom_prog_pkg::*;
    localparam int P = 20;
    localparam logic [6:0] MFG_C = 7'h2C; // arbitrary value
    localparam logic [6:0] DEV_C = 7'h51; // arbitrary value
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic start_i = 1'b0;
    logic [1:0] op_i = 2'h0;
    logic [13:0] addr_i = 14'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic busy, done, fail, perr, oe, cs_n, og_n, pgm_n, vpp, idh;
    logic [7:0] rdata, dout, din;
    logic [13:0] abus;
    int mismatches = 0;
    int checked = 0;
    eprom_prog_ctrl #(.PRIME_CYCLES(P)) u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i), .op_i(op_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy), .done_o(done),
        .fail_o(fail), .parity_err_o(perr), .rdata_o(rdata),
        .addr_bus_o(abus), .byte_pins_i(din), .byte_pins_o(dout),
        .byte_pins_oe_o(oe), .chip_sel_n_o(cs_n), .out_gate_n_o(og_n),
        .burn_strobe_n_o(pgm_n), .vpp_raise_o(vpp), .id_high_volt_o(idh)
    );
    eprom_model #(.MFG(MFG_C), .DEV(DEV_C)) u_dev (
        .clk_i(clk_i), .addr_i(abus), .host_i(dout), .host_oe_i(oe),
        .cs_n_i(cs_n), .og_n_i(og_n), .pgm_n_i(pgm_n), .vpp_i(vpp),
        .idh_i(idh), .bus_o(din)
    );
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 50000)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHK("done", 1'b1, done)
    endtask
    task automatic op(input logic [1:0] o, input logic [13:0] a,
        input logic [7:0] d);
        @(posedge clk_i);
        #1;
        start_i = 1'b1;
        op_i = o;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i);
        #1;
        start_i = 1'b0;
        `CHK("busy", 1'b1, busy)
        wait_done();
    endtask
    task automatic idle();
        `CHK("cs_n", 1'b1, cs_n)
        `CHK("og_n", 1'b1, og_n)
        `CHK("pgm_n", 1'b1, pgm_n)
        `CHK("vpp", 1'b0, vpp)
        `CHK("idh", 1'b0, idh)
        `CHK("oe", 1'b0, oe)
        `CHK("busy", 1'b0, busy)
    endtask
    task automatic refuse();
        int n;
        n = 0;
        u_dev.lens.delete();
        op(OP_READ, 14'h0000, 8'h00);
        @(posedge clk_i);
        #1;
        start_i = 1'b1;
        op_i = OP_READ;
        @(posedge clk_i);
        #1;
        op_i = OP_PROG;
        repeat (3) @(posedge clk_i);
        #1;
        start_i = 1'b0;
        wait_done();
        repeat (100)
        begin
            @(posedge clk_i);
            #1;
            if (done === 1'b1)
                n++;
        end
        `CHK("extra done", 0, n)
        `CHK("stray pulses", 0, u_dev.lens.size())
    endtask
    task automatic prog(input logic [13:0] a, input logic [7:0] d,
        input int x, input logic [7:0] got, input logic f);
        u_dev.need = x;
        u_dev.hits = 0;
        u_dev.lens.delete();
        op(OP_PROG, a, d);
        `CHK("fail", f, fail)
        `CHK("pulses", f ? MAX_PRIME : x + 1, u_dev.lens.size())
        for (int i = 0; i < u_dev.lens.size(); i++)
            // strobe stays low one cycle past the loaded count
            `CHK("width", (f || i < x) ? P + 1 : 3 * x * P + 1,
                u_dev.lens[i])
        `CHK("cell", got, u_dev.mem[a])
        idle();
        op(OP_READ, a, 8'h00);
        `CHK("readback", got, rdata)
    endtask
    initial
    begin
        #2_000_000;
        mismatches++;
        results();
    end
    initial
    begin
        logic [6:0] c;
        repeat (10) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        idle();
        op(OP_READ, 14'h3FFF, 8'h00);
        `CHK("blank", 8'hFF, rdata)
        refuse();
        prog(14'h0123, 8'hA5, 3, 8'hA5, 1'b0);
        prog(14'h3FFF, 8'h00, 25, 8'h00, 1'b0);
        prog(14'h0123, 8'h5A, 1, 8'h00, 1'b1);
        for (int i = 0; i < 2; i++)
        begin
            c = (i == 0) ? MFG_C : DEV_C;
            op(OP_IDENT, i[13:0], 8'h00);
            `CHK("ident", {~^c, c}, rdata)
            `CHK("perr", 1'b0, perr)
        end
        u_dev.bad_par = 1'b1;
        op(OP_IDENT, 14'h0000, 8'h00);
        `CHK("perr bad", 1'b1, perr)
        u_dev.bad_par = 1'b0;
        idle();
        `CHK("pin faults", 0, u_dev.viol)
        results();
    end
endmodule
